// ==== hdl/ipm_regs.vh ====
// Purpose: Constants for the internal RAM process-ID protection block
// Assumes: 32-bit CPU addresses, process identifiers 0 to 7
// Notes:   Register offsets are byte addresses on the plain register port
//
// How it works
// - Boot ROMs, lower instr RAM, middle RAM, lower data RAM: fixed rules.
// - Fixed regions: processes 0 and 1 read, write RAM; others refused.
// - Fast retention RAM, both aliases: mask bit n allows process n.
// - Slow retention RAM: processes 0,1 always; mask bits 0-5 for 2-7.
// - Fast mask writable by process 0 only; slow mask by 0 or 1.
// - Upper 128 KB of instr and data RAM: permit and translate addresses.
// - Each translating unit has exactly 16 pages.
// - Page size field: 0 is 8 KB, 1 is 4 KB, 2 is 2 KB, per unit.
// - Page n starts at unit base plus page size times n.
// - Space above the 16 pages is left untranslated.
// - Untranslated remainder: processes 0 and 1 only.
// - Processes 0 and 1: virtual page maps to same physical page.
// - Processes 2-7: go to configured physical page, same offset.
// - 16 entries per unit: rights bits 6:4, virtual page 3:0; 0/1 write.
// - Rights 0 none, 1 all of 2-7, n only process n.
// - Processes 2-7: instr unit read only, data unit read and write.
`ifndef IPM_REGS_VH
`define IPM_REGS_VH
// Register offsets
`define IPM_FAST_MASK_OFS   8'h00
`define IPM_SLOW_MASK_OFS   8'h04
`define IPM_IPAGE_OFS       8'h08
`define IPM_DPAGE_OFS       8'h0c
`define IPM_STATUS_OFS      8'h10
`define IPM_IMAP_OFS        2'h1
`define IPM_DMAP_OFS        2'h2
// Reset values
`define IPM_FAST_MASK_RST   8'h03
`define IPM_SLOW_MASK_RST   6'h00
`define IPM_PAGE_RST        2'h0
`define IPM_MAP_RST         7'h00
// Map entry fields
`define IPM_RIGHT_HI        6
`define IPM_RIGHT_LO        4
`define IPM_VPAGE_HI        3
`define IPM_VPAGE_LO        0
`define IPM_RIGHT_ALL       3'h1
// Page size codes
`define IPM_PG_4K           2'h1
`define IPM_PG_2K           2'h2
// Address ranges
`define IPM_ROMA_LO         32'h4000_0000
`define IPM_ROMA_HI         32'h4005_ffff
`define IPM_ROMB_LO         32'h3ff9_0000
`define IPM_ROMB_HI         32'h3ff9_ffff
`define IPM_IRAM_LO         32'h4007_0000
`define IPM_IRAM_HI         32'h4007_ffff
`define IPM_MRAM_LO         32'h3ffe_0000
`define IPM_MRAM_HI         32'h3fff_ffff
`define IPM_MRAMB_LO        32'h400a_0000
`define IPM_MRAMB_HI        32'h400b_ffff
`define IPM_DRAM_LO         32'h3ffa_e000
`define IPM_DRAM_HI         32'h3ffb_ffff
`define IPM_FAST_LO         32'h3ff8_0000
`define IPM_FAST_HI         32'h3ff8_1fff
`define IPM_FASTB_LO        32'h400c_0000
`define IPM_FASTB_HI        32'h400c_1fff
`define IPM_SLOW_LO         32'h5000_0000
`define IPM_SLOW_HI         32'h5000_1fff
`define IPM_IMMU_BASE       32'h4008_0000
`define IPM_DMMU_BASE       32'h3ffc_0000
`endif

// ==== hdl/ipm_top.v ====
// Purpose: Process-ID protection and page translation for on-chip RAM
// Assumes: Memory returns read data in the cycle after its request
// Notes:   Each bus port sees only its own translating unit's range
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "ipm_regs.vh"

// One CPU bus port: decide, translate and gate one access per cycle
module ipm_port #(
    parameter [31:0] MMU_BASE = `IPM_IMMU_BASE,
    parameter        MMU_WR   = 1'b0
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Configuration
    input  wire [1:0]   page_sel,
    input  wire [111:0] map_flat,
    input  wire [7:0]   fast_mask,
    input  wire [5:0]   slow_mask,
    // CPU side
    input  wire         req,
    input  wire         we,
    input  wire [31:0]  addr,
    input  wire [31:0]  wdata,
    input  wire [2:0]   pid,
    output reg  [31:0]  rdata,
    output reg          rvalid,
    output reg          viol,
    // Memory side
    output reg          mem_req,
    output reg          mem_we,
    output reg  [31:0]  mem_addr,
    output reg  [31:0]  mem_wdata,
    input  wire [31:0]  mem_rdata
);
    reg         ok;
    reg  [31:0] phys;
    reg         in_pg;
    reg         hit;
    reg  [3:0]  vp;
    reg  [3:0]  pp;
    reg  [6:0]  ent;
    reg  [2:0]  sidx;
    reg  [1:0]  rd_q;
    reg  [1:0]  ok_q;
    wire        priv;
    wire [16:0] off;
    integer     i;

    assign priv = (pid[2:1] == 2'b00);
    assign off  = addr[16:0];

    always @* begin
        ok    = 1'b1;
        phys  = addr;
        in_pg = 1'b1;
        hit   = 1'b0;
        vp    = off[16:13];
        pp    = 4'h0;
        ent   = 7'h00;
        sidx  = pid - 3'd2;
        // Unit geometry, 16 pages whatever the size
        case (page_sel)
            `IPM_PG_4K: begin
                in_pg = ~off[16];
                vp    = off[15:12];
            end
            `IPM_PG_2K: begin
                in_pg = (off[16:15] == 2'b00);
                vp    = off[14:11];
            end
            default:    vp    = off[16:13];
        endcase
        if ((addr >= `IPM_ROMA_LO && addr <= `IPM_ROMA_HI) ||
            (addr >= `IPM_ROMB_LO && addr <= `IPM_ROMB_HI)) begin
            ok = priv & ~we;
        end else if ((addr >= `IPM_IRAM_LO && addr <= `IPM_IRAM_HI) ||
                     (addr >= `IPM_MRAM_LO && addr <= `IPM_MRAM_HI) ||
                     (addr >= `IPM_MRAMB_LO && addr <= `IPM_MRAMB_HI) ||
                     (addr >= `IPM_DRAM_LO && addr <= `IPM_DRAM_HI)) begin
            ok = priv;
        end else if ((addr >= `IPM_FAST_LO && addr <= `IPM_FAST_HI) ||
                     (addr >= `IPM_FASTB_LO && addr <= `IPM_FASTB_HI)) begin
            ok = fast_mask[pid];
        end else if (addr >= `IPM_SLOW_LO && addr <= `IPM_SLOW_HI) begin
            ok = priv | slow_mask[sidx];
        end else if (addr[31:17] == MMU_BASE[31:17]) begin
            if (priv) begin
                ok = 1'b1; // Identity map, whole range
            end else if (!in_pg) begin
                ok = 1'b0;
            end else if (we && !MMU_WR) begin
                ok = 1'b0;
            end else begin
                // Entries index physical pages; lowest match wins
                for (i = 15; i >= 0; i = i - 1) begin
                    ent = map_flat[i*7 +: 7];
                    if (ent[`IPM_VPAGE_HI:`IPM_VPAGE_LO] == vp &&
                        (ent[`IPM_RIGHT_HI:`IPM_RIGHT_LO] == `IPM_RIGHT_ALL ||
                         ent[`IPM_RIGHT_HI:`IPM_RIGHT_LO] == pid)) begin
                        hit = 1'b1;
                        pp  = i[3:0];
                    end
                end
                ok = hit;
                // Base plus size times page, offset kept
                case (page_sel)
                    `IPM_PG_4K: phys = {addr[31:17], 1'b0, pp, off[11:0]};
                    `IPM_PG_2K: phys = {addr[31:17], 2'b00, pp, off[10:0]};
                    default:    phys = {addr[31:17], pp, off[12:0]};
                endcase
            end
        end
    end

    // Refused accesses never reach memory
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            viol      <= 1'b0;
            rd_q      <= 2'b00;
            ok_q      <= 2'b00;
            rdata     <= 32'h0000_0000;
            rvalid    <= 1'b0;
        end else begin
            mem_req   <= req & ok;
            mem_we    <= req & we & ok;
            mem_addr  <= (req & ok) ? phys : 32'h0000_0000;
            mem_wdata <= (req & we & ok) ? wdata : 32'h0000_0000;
            viol      <= req & ~ok;
            rd_q      <= {rd_q[0], req & ~we};
            ok_q      <= {ok_q[0], ok};
            rvalid    <= rd_q[1];
            rdata     <= (rd_q[1] & ok_q[1]) ? mem_rdata : 32'h0;
        end
    end
endmodule

module ipm_top (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         rstn,
    // Register port
    input  wire [7:0]   reg_addr,
    input  wire [31:0]  reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    input  wire [2:0]   reg_pid,
    output reg  [31:0]  reg_rdata,
    // Instruction bus
    input  wire         ibus_req,
    input  wire         ibus_we,
    input  wire [31:0]  ibus_addr,
    input  wire [31:0]  ibus_wdata,
    input  wire [2:0]   ibus_pid,
    output wire [31:0]  ibus_rdata,
    output wire         ibus_rvalid,
    output wire         ibus_viol,
    // Instruction memory side
    output wire         imem_req,
    output wire         imem_we,
    output wire [31:0]  imem_addr,
    output wire [31:0]  imem_wdata,
    input  wire [31:0]  imem_rdata,
    // Data bus
    input  wire         dbus_req,
    input  wire         dbus_we,
    input  wire [31:0]  dbus_addr,
    input  wire [31:0]  dbus_wdata,
    input  wire [2:0]   dbus_pid,
    output wire [31:0]  dbus_rdata,
    output wire         dbus_rvalid,
    output wire         dbus_viol,
    // Data memory side
    output wire         dmem_req,
    output wire         dmem_we,
    output wire [31:0]  dmem_addr,
    output wire [31:0]  dmem_wdata,
    input  wire [31:0]  dmem_rdata
);
    reg  [1:0]   rst_sync;
    wire         rst_n;
    reg  [7:0]   fast_mask;
    reg  [5:0]   slow_mask;
    reg  [1:0]   instr_ram_page_size_sel;
    reg  [1:0]   data_ram_page_size_sel;
    reg  [6:0]   imap [0:15];
    reg  [6:0]   dmap [0:15];
    reg  [2:0]   status;
    reg  [111:0] imap_flat;
    reg  [111:0] dmap_flat;
    reg  [31:0]  next_rdata;
    reg  [2:0]   next_status;
    wire         sys_wr;
    wire         map_sel;
    integer      k;
    integer      j;

    // Release reset through two flops
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Writer identity comes with each register write
    assign sys_wr  = reg_wr & (reg_pid[2:1] == 2'b00);
    assign map_sel = (reg_addr[7:6] == `IPM_IMAP_OFS) ||
                     (reg_addr[7:6] == `IPM_DMAP_OFS);

    always @* begin
        for (j = 0; j < 16; j = j + 1) begin
            imap_flat[j*7 +: 7] = imap[j];
            dmap_flat[j*7 +: 7] = dmap[j];
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_mask               <= `IPM_FAST_MASK_RST;
            slow_mask               <= `IPM_SLOW_MASK_RST;
            instr_ram_page_size_sel <= `IPM_PAGE_RST;
            data_ram_page_size_sel  <= `IPM_PAGE_RST;
            for (k = 0; k < 16; k = k + 1) begin
                imap[k] <= `IPM_MAP_RST;
                dmap[k] <= `IPM_MAP_RST;
            end
        end else if (reg_wr) begin
            if (reg_addr == `IPM_FAST_MASK_OFS && reg_pid == 3'd0)
                fast_mask <= reg_wdata[7:0];
            if (reg_addr == `IPM_SLOW_MASK_OFS && sys_wr)
                slow_mask <= reg_wdata[5:0];
            if (reg_addr == `IPM_IPAGE_OFS && sys_wr)
                instr_ram_page_size_sel <= reg_wdata[1:0];
            if (reg_addr == `IPM_DPAGE_OFS && sys_wr)
                data_ram_page_size_sel <= reg_wdata[1:0];
            if (reg_addr[7:6] == `IPM_IMAP_OFS && sys_wr &&
                reg_addr[1:0] == 2'b00)
                imap[reg_addr[5:2]] <= reg_wdata[6:0];
            if (reg_addr[7:6] == `IPM_DMAP_OFS && sys_wr &&
                reg_addr[1:0] == 2'b00)
                dmap[reg_addr[5:2]] <= reg_wdata[6:0];
        end
    end

    // Sticky events; a new event beats a clearing write
    always @* begin
        next_status = status;
        if (reg_wr && reg_addr == `IPM_STATUS_OFS)
            next_status = status & ~reg_wdata[2:0];
        next_status[0] = next_status[0] | ibus_viol;
        next_status[1] = next_status[1] | dbus_viol;
        if (reg_wr && !sys_wr &&
            (reg_addr == `IPM_SLOW_MASK_OFS || reg_addr == `IPM_IPAGE_OFS ||
             reg_addr == `IPM_DPAGE_OFS || map_sel))
            next_status[2] = 1'b1;
        if (reg_wr && reg_pid != 3'd0 && reg_addr == `IPM_FAST_MASK_OFS)
            next_status[2] = 1'b1;
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            `IPM_FAST_MASK_OFS: next_rdata = {24'h0, fast_mask};
            `IPM_SLOW_MASK_OFS: next_rdata = {26'h0, slow_mask};
            `IPM_IPAGE_OFS: next_rdata = {30'h0, instr_ram_page_size_sel};
            `IPM_DPAGE_OFS: next_rdata = {30'h0, data_ram_page_size_sel};
            `IPM_STATUS_OFS:    next_rdata = {29'h0, status};
            default:            next_rdata = 32'h0000_0000;
        endcase
        if (reg_addr[7:6] == `IPM_IMAP_OFS)
            next_rdata = {25'h0, imap[reg_addr[5:2]]};
        if (reg_addr[7:6] == `IPM_DMAP_OFS)
            next_rdata = {25'h0, dmap[reg_addr[5:2]]};
        if (reg_addr[1:0] != 2'b00)
            next_rdata = 32'h0000_0000;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status    <= 3'b000;
            reg_rdata <= 32'h0000_0000;
        end else begin
            status    <= next_status;
            reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    // Instruction side: translated range read only for processes 2-7
    ipm_port #(.MMU_BASE(`IPM_IMMU_BASE), .MMU_WR(1'b0)) u_iport (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .page_sel  (instr_ram_page_size_sel),
        .map_flat  (imap_flat),
        .fast_mask (fast_mask),
        .slow_mask (slow_mask),
        .req       (ibus_req),
        .we        (ibus_we),
        .addr      (ibus_addr),
        .wdata     (ibus_wdata),
        .pid       (ibus_pid),
        .rdata     (ibus_rdata),
        .rvalid    (ibus_rvalid),
        .viol      (ibus_viol),
        .mem_req   (imem_req),
        .mem_we    (imem_we),
        .mem_addr  (imem_addr),
        .mem_wdata (imem_wdata),
        .mem_rdata (imem_rdata)
    );

    ipm_port #(.MMU_BASE(`IPM_DMMU_BASE), .MMU_WR(1'b1)) u_dport (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .page_sel  (data_ram_page_size_sel),
        .map_flat  (dmap_flat),
        .fast_mask (fast_mask),
        .slow_mask (slow_mask),
        .req       (dbus_req),
        .we        (dbus_we),
        .addr      (dbus_addr),
        .wdata     (dbus_wdata),
        .pid       (dbus_pid),
        .rdata     (dbus_rdata),
        .rvalid    (dbus_rvalid),
        .viol      (dbus_viol),
        .mem_req   (dmem_req),
        .mem_we    (dmem_we),
        .mem_addr  (dmem_addr),
        .mem_wdata (dmem_wdata),
        .mem_rdata (dmem_rdata)
    );
endmodule

// ==== sim/ipm_mem_model.sv ====
// Purpose: Memory behind one port of the protection block
// Assumes: Read data is due in the cycle after a memory request
// Notes:   Data is derived from the address so the bench can predict it
module ipm_mem_model (
    // Clock
    input  wire         sys_clk,
    // Request
    input  wire         req,
    input  wire         we,
    input  wire  [31:0] addr,
    // Answer
    output logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial rdata = 32'h0;
    // Idle cycles invert the data so a stale value never matches
    always @(posedge sys_clk) begin
        if (req && !we) begin
            rdata <= addr ^ 32'h5a5a_5a5a;
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// ==== sim/ipm_monitor.sv ====
// Purpose: Port-level assertions for the protection block
// Assumes: Requests only start after the internal reset is released
// Notes:   Config-dependent decisions are left to the bench
`include "ipm_regs.vh"
module ipm_monitor (
    // Clock and reset
    input wire        sys_clk,
    input wire        rstn,
    // Instruction side
    input wire        ibus_req,
    input wire        ibus_we,
    input wire [31:0] ibus_addr,
    input wire [2:0]  ibus_pid,
    input wire [31:0] ibus_rdata,
    input wire        ibus_rvalid,
    input wire        ibus_viol,
    input wire        imem_req,
    // Data side
    input wire        dbus_req,
    input wire        dbus_we,
    input wire [31:0] dbus_addr,
    input wire [2:0]  dbus_pid,
    input wire [31:0] dbus_rdata,
    input wire        dbus_rvalid,
    input wire        dbus_viol,
    input wire        dmem_req,
    input wire        dmem_we,
    input wire [31:0] dmem_addr,
    input wire [31:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    function automatic bit rng(logic [31:0] a, logic [31:0] lo,
                               logic [31:0] sz);
        return a >= lo && a - lo < sz;
    endfunction
    sequence i_ref_rd;
        ibus_req && !ibus_we ##1 ibus_viol;
    endsequence
    sequence d_rd_go;
        dbus_req && !dbus_we ##1 dmem_req;
    endsequence
    i_excl_a: assert property (ibus_viol |-> !imem_req)
        else $error("ibus refusal reached memory");
    d_excl_a: assert property (dbus_viol |-> !dmem_req && !dmem_we)
        else $error("dbus refusal reached memory");
    fix_deny_a: assert property (
        dbus_req && dbus_pid > 3'h1 && rng(dbus_addr, `IPM_MRAM_LO,
        32'h2_0000) |=> dbus_viol && !dmem_req)
        else $error("fixed region granted to user process");
    fix_pass_a: assert property (
        dbus_req && dbus_pid < 3'h2 && rng(dbus_addr, `IPM_MRAM_LO,
        32'h2_0000) |=> dmem_req && dmem_addr == $past(dbus_addr))
        else $error("fixed region refused to system process");
    ident_map_a: assert property (
        dbus_req && dbus_pid < 3'h2 && rng(dbus_addr, `IPM_DMMU_BASE,
        32'h2_0000) |=> dmem_req && dmem_addr == $past(dbus_addr))
        else $error("system process address translated");
    slow_os_a: assert property (
        dbus_req && dbus_pid < 3'h2 && rng(dbus_addr, `IPM_SLOW_LO,
        32'h2000) |=> dmem_req)
        else $error("slow retention RAM refused to system process");
    iram_ro_a: assert property (
        ibus_req && ibus_we && ibus_pid > 3'h1 && rng(ibus_addr,
        `IPM_IMMU_BASE, 32'h2_0000) |=> ibus_viol)
        else $error("user write to instruction unit accepted");
    ref_zero_a: assert property (
        i_ref_rd |-> ##2 ibus_rvalid && ibus_rdata == 32'h0)
        else $error("refused read returned data");
    rd_return_a: assert property (
        d_rd_go |-> ##2 dbus_rvalid && dbus_rdata == $past(dmem_rdata))
        else $error("granted read lost memory data");
endmodule
bind ipm_top ipm_monitor u_mon (.sys_clk, .rstn, .ibus_req, .ibus_we,
    .ibus_addr, .ibus_pid, .ibus_rdata, .ibus_rvalid, .ibus_viol,
    .imem_req, .dbus_req, .dbus_we, .dbus_addr, .dbus_pid, .dbus_rdata,
    .dbus_rvalid, .dbus_viol, .dmem_req, .dmem_we, .dmem_addr,
    .dmem_rdata);

// ==== sim/ipm_top_tb.sv ====
// Purpose: Self-checking bench for the protection block
// Assumes: Latencies are fixed, so every wait is a fixed cycle count
// Notes:   Index 0 is the instruction bus, index 1 the data bus
`include "ipm_regs.vh"
module ipm_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic            sys_clk = 1'b0;
    logic            rstn = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [31:0]     reg_wdata = 32'h0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [2:0]      reg_pid = 3'h0;
    logic [1:0]      req = 2'h0;
    logic [1:0]      we = 2'h0;
    logic [1:0][31:0] addr = '0;
    logic [1:0][31:0] wdata = '0;
    logic [1:0][2:0] pid = '0;
    wire  [31:0]     reg_rdata;
    wire  [1:0]      rvalid, viol, mreq, mwe;
    wire  [1:0][31:0] rdata, maddr, mwdata, mrdata;
    int              errors = 0;
    int              n_tests = 0;

    always #2 sys_clk = ~sys_clk;

    ipm_top DUT (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_pid, .reg_rdata, .ibus_req(req[0]), .ibus_we(we[0]),
        .ibus_addr(addr[0]), .ibus_wdata(wdata[0]), .ibus_pid(pid[0]),
        .ibus_rdata(rdata[0]), .ibus_rvalid(rvalid[0]), .ibus_viol(viol[0]),
        .imem_req(mreq[0]), .imem_we(mwe[0]), .imem_addr(maddr[0]),
        .imem_wdata(mwdata[0]), .imem_rdata(mrdata[0]),
        .dbus_req(req[1]), .dbus_we(we[1]), .dbus_addr(addr[1]),
        .dbus_wdata(wdata[1]), .dbus_pid(pid[1]), .dbus_rdata(rdata[1]),
        .dbus_rvalid(rvalid[1]), .dbus_viol(viol[1]), .dmem_req(mreq[1]),
        .dmem_we(mwe[1]), .dmem_addr(maddr[1]), .dmem_wdata(mwdata[1]),
        .dmem_rdata(mrdata[1]));
    ipm_mem_model u_imem (.sys_clk, .req(mreq[0]), .we(mwe[0]),
        .addr(maddr[0]), .rdata(mrdata[0]));
    ipm_mem_model u_dmem (.sys_clk, .req(mreq[1]), .we(mwe[1]),
        .addr(maddr[1]), .rdata(mrdata[1]));

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] p);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_pid <= p;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", exp, reg_rdata);
    endtask
    // One access; ok and pa give the expected decision and physical address
    task automatic acc(input bit u, input bit w, input logic [31:0] a,
                       input logic [2:0] p, input bit ok,
                       input logic [31:0] pa);
        @(posedge sys_clk);
        req[u] <= 1'b1;
        we[u] <= w;
        addr[u] <= a;
        wdata[u] <= ~a;
        pid[u] <= p;
        @(posedge sys_clk);
        req[u] <= 1'b0;
        #1;
        check("viol", {31'h0, !ok}, {31'h0, viol[u]});
        check("mem_req", {31'h0, ok}, {31'h0, mreq[u]});
        check("mem_we", {31'h0, ok && w}, {31'h0, mwe[u]});
        check("mem_addr", ok ? pa : 32'h0, maddr[u]);
        check("mem_wdata", (ok && w) ? ~a : 32'h0, mwdata[u]);
        if (!w) begin
            repeat (2) @(posedge sys_clk);
            #1;
            check("rvalid", 32'h1, {31'h0, rvalid[u]});
            check("rdata", ok ? pa ^ 32'h5a5a_5a5a : 32'h0, rdata[u]);
        end
    endtask

    task automatic t_regs;
        rd(`IPM_FAST_MASK_OFS, `IPM_FAST_MASK_RST);
        rd(`IPM_SLOW_MASK_OFS, `IPM_SLOW_MASK_RST);
        rd(`IPM_IPAGE_OFS, `IPM_PAGE_RST);
        rd(8'h80, `IPM_MAP_RST);
        rd(`IPM_DPAGE_OFS, `IPM_PAGE_RST);
        wr(`IPM_IPAGE_OFS, 32'h1, 3'h3);
        rd(`IPM_IPAGE_OFS, `IPM_PAGE_RST);
        rd(8'hfc, 32'h0);
    endtask
    task automatic t_fast;
        wr(`IPM_FAST_MASK_OFS, 32'h04, 3'h1);
        rd(`IPM_FAST_MASK_OFS, `IPM_FAST_MASK_RST);
        rd(`IPM_STATUS_OFS, 32'h4);
        wr(`IPM_STATUS_OFS, 32'h7, 3'h0);
        wr(`IPM_FAST_MASK_OFS, 32'h04, 3'h0);
        rd(`IPM_FAST_MASK_OFS, 32'h04);
        acc(1, 0, 32'h3ff8_0010, 3'h1, 0, 0);
        acc(0, 1, 32'h400c_0010, 3'h2, 1, 32'h400c_0010);
    endtask
    task automatic t_slow;
        wr(`IPM_SLOW_MASK_OFS, 32'h3f, 3'h2);
        wr(`IPM_SLOW_MASK_OFS, 32'h01, 3'h1);
        rd(`IPM_SLOW_MASK_OFS, 32'h01);
        acc(1, 1, 32'h5000_1ffc, 3'h2, 1, 32'h5000_1ffc);
        acc(1, 0, 32'h5000_0000, 3'h3, 0, 0);
        acc(1, 0, 32'h5000_0040, 3'h0, 1, 32'h5000_0040);
    endtask
    task automatic t_fixed;
        for (int p = 0; p < 8; p++) begin
            acc(1, p[0], `IPM_MRAM_LO + p * 4, p[2:0], p < 2,
                `IPM_MRAM_LO + p * 4);
        end
        acc(0, 0, `IPM_IRAM_LO, 3'h7, 0, 0);
        acc(1, 0, `IPM_DRAM_HI - 3, 3'h1, 1, `IPM_DRAM_HI - 3);
        acc(0, 0, `IPM_ROMA_LO, 3'h0, 1, `IPM_ROMA_LO);
        acc(1, 1, `IPM_ROMB_LO, 3'h0, 0, 0);
        rd(`IPM_STATUS_OFS, 32'h7);
    endtask
    task automatic t_mmu;
        logic [31:0] sz;
        logic [31:0] b;
        wr(8'h88, 32'h21, 3'h0);
        acc(1, 0, 32'h3ffc_2345, 3'h2, 1, 32'h3ffc_4345);
        acc(1, 0, 32'h3ffc_2345, 3'h3, 0, 0);
        acc(1, 1, 32'h3ffc_2345, 3'h1, 1, 32'h3ffc_2345);
        wr(8'h94, 32'h13, 3'h2);
        rd(8'h94, 32'h0);
        for (int u = 0; u < 2; u++) begin
            b = u ? `IPM_DMMU_BASE : `IPM_IMMU_BASE;
            wr(u ? 8'h94 : 8'h54, 32'h13, 3'h1);
            for (int ps = 0; ps < 3; ps++) begin
                sz = 32'h2000 >> ps;
                wr(u ? `IPM_DPAGE_OFS : `IPM_IPAGE_OFS, ps, 3'h1);
                acc(u, 0, b + 3 * sz + 16, 3'h4, 1, b + 5 * sz + 16);
                acc(u, 1, b + 3 * sz + 16, 3'h4, u, b + 5 * sz + 16);
                acc(u, 0, b + 3 * sz + 16, 3'h0, 1, b + 3 * sz + 16);
                acc(u, 0, b + 16 * sz - 4, 3'h5, 0, 0);
                if (ps > 0) begin
                    acc(u, 0, b + 16 * sz, 3'h2, 0, 0);
                    acc(u, 1, b + 16 * sz + 8, 3'h1, 1, b + 16 * sz + 8);
                end
            end
        end
        b = `IPM_DMMU_BASE;
        wr(`IPM_DPAGE_OFS, 32'h3, 3'h1);
        acc(1, 0, b + 32'h6010, 3'h4, 1, b + 32'ha010);
    endtask

    task automatic end_sim;
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        errors++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs;
        t_fast;
        t_slow;
        t_fixed;
        t_mmu;
        end_sim;
    end
endmodule
